// ===== design/nce_defs.vh
// Constants for the nibble core execute unit: operation codes, flag bits, reset values, stack depth.
// Assumes an external decoder presents one decoded operation per cycle.
`ifndef NCE_DEFS_VH
`define NCE_DEFS_VH
`define NCE_OP_NOP 6'h00
`define NCE_OP_ADD 6'h01
`define NCE_OP_SUB 6'h02
`define NCE_OP_ROR 6'h03
`define NCE_OP_ALE 6'h04
`define NCE_OP_ANE 6'h05
`define NCE_OP_MLE 6'h06
`define NCE_OP_MNE 6'h07
`define NCE_OP_YNE 6'h08
`define NCE_OP_XNE 6'h09
`define NCE_OP_MBSET 6'h0A
`define NCE_OP_MBCLR 6'h0B
`define NCE_OP_TBIT 6'h0C
`define NCE_OP_PSET 6'h0D
`define NCE_OP_PCLR 6'h0E
`define NCE_OP_PTST 6'h0F
`define NCE_OP_CYCLR 6'h10
`define NCE_OP_CYSET 6'h11
`define NCE_OP_CYTST 6'h12
`define NCE_OP_LDMEM 6'h13
`define NCE_OP_SWAP 6'h14
`define NCE_OP_LDWI 6'h15
`define NCE_OP_PLDI 6'h16
`define NCE_OP_PFRA 6'h17
`define NCE_OP_AFRP 6'h18
`define NCE_OP_BRA 6'h19
`define NCE_OP_BRI 6'h1A
`define NCE_OP_CALA 6'h1B
`define NCE_OP_CALI 6'h1C
`define NCE_OP_RETN 6'h1D
`define NCE_OP_IRET 6'h1E
`define NCE_OP_IEN 6'h1F
`define NCE_OP_IDIS 6'h20
`define NCE_OP_XEN 6'h21
`define NCE_OP_XDIS 6'h22
`define NCE_OP_NEG 6'h23
`define NCE_OP_LDA 6'h24
`define NCE_OP_WDCLR 6'h25
// Target selectors for arithmetic
`define NCE_TG_ACC 3'h0
`define NCE_TG_MEM 3'h1
`define NCE_TG_ABN 3'h2
`define NCE_TG_DBN 3'h3
`define NCE_TG_X 3'h4
`define NCE_TG_Y 3'h5
// Operand selectors
`define NCE_SRC_IMM 2'h0
`define NCE_SRC_ACC 2'h1
`define NCE_SRC_Y 2'h2
`define NCE_SRC_MEM 2'h3
// Flag register bit positions
`define NCE_FL_S 0
`define NCE_FL_C 1
`define NCE_FL_D 2
`define NCE_FL_I 3
`define NCE_FLAGS_RST 4'h1
`define NCE_STKPTR_RST 3'h7
`define NCE_FSP_RST 3'h7
`define NCE_STK_DEPTH 8
`endif

// ===== design/nce_execute.v
// Execute unit of a 4-bit microcontroller core: ALU, flags, index addressing,
// data RAM, peripheral nibbles, address stack and table read.
// Assumes a decoder outside presents opValid/opCode/operands, and a program ROM
// answers romWord one cycle after romAddr is issued.
`include "nce_defs.vh"

module nce_execute (
    sys_clk,
    reset,
    opValid,
    opCode,
    opTarget,
    opSource,
    opImm,
    opSel,
    opDirect,
    opAbs,
    romWord,
    busy_ff,
    acc_ff,
    xIdx_ff,
    yIdx_ff,
    flags_ff,
    pc_ff,
    romPage_ff,
    romAddr_ff,
    addrBuf_ff,
    dataBuf_ff,
    stackPtr_ff,
    flagStackPtr_ff,
    wdClear_ff
);
    input wire sys_clk;
    input wire reset;
    input wire opValid;
    input wire [5:0] opCode;
    input wire [2:0] opTarget;
    input wire [1:0] opSource;
    input wire [3:0] opImm;
    input wire [1:0] opSel;
    input wire [7:0] opDirect;
    input wire [13:0] opAbs;
    input wire [15:0] romWord;
    output reg busy_ff;
    output reg [3:0] acc_ff;
    output reg [3:0] xIdx_ff;
    output reg [3:0] yIdx_ff;
    output reg [3:0] flags_ff;
    output reg [13:0] pc_ff;
    output reg romPage_ff;
    output reg [14:0] romAddr_ff;
    output reg [14:0] addrBuf_ff;
    output reg [15:0] dataBuf_ff;
    output reg [2:0] stackPtr_ff;
    output reg [2:0] flagStackPtr_ff;
    output reg wdClear_ff;

    localparam ST_RUN = 2'b01;
    localparam ST_TBL = 2'b10;

    reg [1:0] state_ff;
    reg [3:0] dataMem [0:255];
    reg [3:0] periph [0:63];
    reg [14:0] addrStack [0:`NCE_STK_DEPTH-1];
    reg [3:0] flagStack [0:`NCE_STK_DEPTH-1];
    integer i;

    function [3:0] getNib;
        input [15:0] word;
        input [1:0] sel;
        begin
            getNib = word[sel*4 +: 4];
        end
    endfunction

    // Adds or subtracts with carry in; result carries the carry/borrow in bit 4
    function [4:0] addSub;
        input isSub;
        input [3:0] a;
        input [3:0] b;
        input cin;
        begin
            if (isSub)
                addSub = {1'b0, a} - {1'b0, b} - {4'h0, cin};
            else
                addSub = {1'b0, a} + {1'b0, b} + {4'h0, cin};
        end
    endfunction

    wire carry = flags_ff[`NCE_FL_C];
    wire status = flags_ff[`NCE_FL_S];
    wire [7:0] memAddr = flags_ff[`NCE_FL_D] ? (opDirect + {4'h0, xIdx_ff} + {4'h0, yIdx_ff})
                                             : opDirect;
    wire [3:0] memVal = dataMem[memAddr];
    wire [5:0] perAddr = opDirect[5:0];
    wire [3:0] perVal = periph[perAddr];
    wire [15:0] abWide = {1'b0, addrBuf_ff};

    reg [3:0] tgtVal;
    reg [3:0] srcVal;
    reg [4:0] arith;
    always @*
    begin
        case (opTarget)
            `NCE_TG_MEM: tgtVal = memVal;
            `NCE_TG_ABN: tgtVal = getNib(abWide, opSel);
            `NCE_TG_DBN: tgtVal = getNib(dataBuf_ff, opSel);
            `NCE_TG_X: tgtVal = xIdx_ff;
            `NCE_TG_Y: tgtVal = yIdx_ff;
            default: tgtVal = acc_ff;
        endcase
        case (opSource)
            `NCE_SRC_ACC: srcVal = acc_ff;
            `NCE_SRC_Y: srcVal = yIdx_ff;
            `NCE_SRC_MEM: srcVal = memVal;
            default: srcVal = opImm;
        endcase
        arith = addSub(opCode == `NCE_OP_SUB, tgtVal, srcVal, carry);
    end

    wire [3:0] arithRes = arith[3:0];
    wire arithCy = arith[4];
    wire [3:0] bitMask = 4'h1 << opSel;
    wire [3:0] cmplRes = ~acc_ff + 4'h1;
    wire [14:0] pushVal = {romPage_ff, pc_ff};
    wire [2:0] spDec = stackPtr_ff - 3'h1;
    wire [2:0] spInc = stackPtr_ff + 3'h1;
    wire [2:0] fspInc = flagStackPtr_ff + 3'h1;

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff <= ST_RUN;
            busy_ff <= 1'b0;
            acc_ff <= 4'h0;
            xIdx_ff <= 4'h0;
            yIdx_ff <= 4'h0;
            flags_ff <= `NCE_FLAGS_RST;
            pc_ff <= 14'h0000;
            romPage_ff <= 1'b0;
            romAddr_ff <= 15'h0000;
            addrBuf_ff <= 15'h0000;
            dataBuf_ff <= 16'h0000;
            stackPtr_ff <= `NCE_STKPTR_RST;
            flagStackPtr_ff <= `NCE_FSP_RST;
            wdClear_ff <= 1'b0;
        end
        else
        begin
            wdClear_ff <= 1'b0;
            romAddr_ff <= {romPage_ff, pc_ff};
            case (state_ff)
                ST_TBL:
                begin
                    // Second cycle: capture word, restore counter, pop
                    dataBuf_ff <= romWord;
                    romPage_ff <= addrStack[stackPtr_ff][14];
                    pc_ff <= addrStack[stackPtr_ff][13:0];
                    stackPtr_ff <= spInc;
                    busy_ff <= 1'b0;
                    state_ff <= ST_RUN;
                end
                ST_RUN:
                begin
                    if (opValid)
                    begin
                        case (opCode)
                            `NCE_OP_ADD, `NCE_OP_SUB:
                            begin
                                flags_ff[`NCE_FL_C] <= arithCy;
                                flags_ff[`NCE_FL_S] <= (opCode == `NCE_OP_ADD) ? arithCy
                                                                                 : ~arithCy;
                                case (opTarget)
                                    `NCE_TG_ABN:
                                    begin
                                        if (opSel == 2'h3)
                                            addrBuf_ff[14:12] <= arithRes[2:0];
                                        else
                                            addrBuf_ff[opSel*4 +: 4] <= arithRes;
                                    end
                                    `NCE_TG_DBN: dataBuf_ff[opSel*4 +: 4] <= arithRes;
                                    `NCE_TG_X: xIdx_ff <= arithRes;
                                    `NCE_TG_Y: yIdx_ff <= arithRes;
                                    default: acc_ff <= arithRes;
                                endcase
                            end
                            `NCE_OP_ROR:
                            begin
                                acc_ff <= {carry, acc_ff[3:1]};
                                flags_ff[`NCE_FL_C] <= acc_ff[0];
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_ALE: flags_ff[`NCE_FL_S] <= (acc_ff <= srcVal);
                            `NCE_OP_ANE: flags_ff[`NCE_FL_S] <= (acc_ff != srcVal);
                            `NCE_OP_MLE: flags_ff[`NCE_FL_S] <= (memVal <= opImm);
                            `NCE_OP_MNE: flags_ff[`NCE_FL_S] <= (memVal != opImm);
                            `NCE_OP_YNE: flags_ff[`NCE_FL_S] <= (yIdx_ff != srcVal);
                            `NCE_OP_XNE: flags_ff[`NCE_FL_S] <= (xIdx_ff != opImm);
                            `NCE_OP_MBSET, `NCE_OP_MBCLR: flags_ff[`NCE_FL_S] <= 1'b1;
                            `NCE_OP_TBIT: flags_ff[`NCE_FL_S] <= |(memVal & bitMask);
                            `NCE_OP_PTST: flags_ff[`NCE_FL_S] <= |(perVal & bitMask);
                            `NCE_OP_CYCLR:
                            begin
                                flags_ff[`NCE_FL_C] <= 1'b0;
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_CYSET:
                            begin
                                flags_ff[`NCE_FL_C] <= 1'b1;
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_CYTST: flags_ff[`NCE_FL_S] <= carry;
                            `NCE_OP_SWAP:
                            begin
                                acc_ff <= memVal;
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_LDA:
                            begin
                                acc_ff <= srcVal;
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_AFRP:
                            begin
                                acc_ff <= perVal;
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_LDWI:
                            begin
                                // First cycle: push, jump to buffer address
                                addrStack[spDec] <= pushVal;
                                stackPtr_ff <= spDec;
                                romPage_ff <= addrBuf_ff[14];
                                pc_ff <= addrBuf_ff[13:0];
                                romAddr_ff <= addrBuf_ff;
                                busy_ff <= 1'b1;
                                state_ff <= ST_TBL;
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_BRA:
                            begin
                                if (status)
                                    pc_ff <= opAbs;
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_BRI:
                            begin
                                if (status)
                                begin
                                    romPage_ff <= addrBuf_ff[14];
                                    pc_ff <= addrBuf_ff[13:0];
                                end
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_CALA, `NCE_OP_CALI:
                            begin
                                if (status)
                                begin
                                    addrStack[spDec] <= pushVal;
                                    stackPtr_ff <= spDec;
                                    if (opCode == `NCE_OP_CALA)
                                        pc_ff <= opAbs;
                                    else
                                    begin
                                        romPage_ff <= addrBuf_ff[14];
                                        pc_ff <= addrBuf_ff[13:0];
                                    end
                                end
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_RETN:
                            begin
                                romPage_ff <= addrStack[stackPtr_ff][14];
                                pc_ff <= addrStack[stackPtr_ff][13:0];
                                stackPtr_ff <= spInc;
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            `NCE_OP_IRET:
                            begin
                                flagStackPtr_ff <= fspInc;
                                flags_ff <= flagStack[fspInc];
                                romPage_ff <= addrStack[stackPtr_ff][14];
                                pc_ff <= addrStack[stackPtr_ff][13:0];
                                stackPtr_ff <= spInc;
                            end
                            `NCE_OP_IEN: flags_ff <= flags_ff | (4'h1 << `NCE_FL_I);
                            `NCE_OP_IDIS: flags_ff <= flags_ff & ~(4'h1 << `NCE_FL_I);
                            `NCE_OP_XEN: flags_ff <= flags_ff | (4'h1 << `NCE_FL_D);
                            `NCE_OP_XDIS: flags_ff <= flags_ff & ~(4'h1 << `NCE_FL_D);
                            `NCE_OP_NEG:
                            begin
                                acc_ff <= cmplRes;
                                flags_ff[`NCE_FL_S] <= (cmplRes == 4'h0);
                            end
                            `NCE_OP_WDCLR:
                            begin
                                wdClear_ff <= 1'b1;
                                flags_ff[`NCE_FL_S] <= 1'b1;
                            end
                            default: flags_ff[`NCE_FL_S] <= 1'b1;
                        endcase
                    end
                end
                default: state_ff <= ST_RUN;
            endcase
        end
    end

    // Data RAM and peripheral nibble writes
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            for (i = 0; i < 64; i = i + 1)
                periph[i] <= 4'h0;
            // Flag stack holds reset flags; nothing in this unit writes it after reset
            for (i = 0; i < `NCE_STK_DEPTH; i = i + 1)
                flagStack[i] <= `NCE_FLAGS_RST;
        end
        else if (opValid && state_ff == ST_RUN)
        begin
            case (opCode)
                `NCE_OP_MBSET: dataMem[memAddr] <= memVal | bitMask;
                `NCE_OP_MBCLR: dataMem[memAddr] <= memVal & ~bitMask;
                `NCE_OP_LDMEM: dataMem[memAddr] <= srcVal;
                `NCE_OP_SWAP: dataMem[memAddr] <= acc_ff;
                `NCE_OP_PSET: periph[perAddr] <= perVal | bitMask;
                `NCE_OP_PCLR: periph[perAddr] <= perVal & ~bitMask;
                `NCE_OP_PLDI: periph[perAddr] <= opImm;
                `NCE_OP_PFRA: periph[perAddr] <= acc_ff;
                default: periph[perAddr] <= perVal;
            endcase
        end
    end

endmodule // nce_execute

// ===== tb/nce_execute_asserts.sv
// Checker for the nibble execute unit: table read, carry, stack and branch relations.
// Assumes nce_defs.vh on the include path; an op counts only when taken with busy_ff low.
`include "nce_defs.vh"
module nce_execute_asserts (
    input wire sys_clk,
    input wire reset,
    input wire opValid,
    input wire [5:0] opCode,
    input wire [13:0] opAbs,
    input wire busy_ff,
    input wire [3:0] acc_ff,
    input wire [3:0] flags_ff,
    input wire [13:0] pc_ff,
    input wire [14:0] romAddr_ff,
    input wire [14:0] addrBuf_ff,
    input wire [2:0] stackPtr_ff
);
    wire opTaken;
    assign opTaken = opValid && !busy_ff;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    sequence tableStart;
        opTaken && opCode == `NCE_OP_LDWI;
    endsequence
    sequence tableBusy;
        tableStart ##1 busy_ff;
    endsequence
    a_table_addr:
        assert property (tableStart |=> busy_ff && romAddr_ff == $past(addrBuf_ff))
        else $error("table read start wrong");
    a_table_stack:
        assert property (tableBusy |=> !busy_ff && stackPtr_ff == $past(stackPtr_ff, 2))
        else $error("table read end wrong");
    a_carry_keep:
        assert property (opTaken && opCode inside {`NCE_OP_ALE, `NCE_OP_ANE, `NCE_OP_MLE,
            `NCE_OP_MNE, `NCE_OP_YNE, `NCE_OP_XNE, `NCE_OP_MBSET, `NCE_OP_MBCLR, `NCE_OP_TBIT,
            `NCE_OP_PSET, `NCE_OP_PCLR, `NCE_OP_PTST, `NCE_OP_CYTST, `NCE_OP_LDMEM, `NCE_OP_SWAP,
            `NCE_OP_LDA, `NCE_OP_NEG} |=> $stable(flags_ff[1]))
        else $error("carry changed");
    a_carry_force:
        assert property (opTaken && (opCode == `NCE_OP_CYSET || opCode == `NCE_OP_CYCLR)
            |=> flags_ff[1] == $past(opCode[0]))
        else $error("carry not forced");
    a_rotate_carry:
        assert property (opTaken && opCode == `NCE_OP_ROR |=> flags_ff[1] == $past(acc_ff[0])
            && acc_ff == {$past(flags_ff[1]), $past(acc_ff[3:1])})
        else $error("rotate wrong");
    a_twos_complement_op_zero:
        assert property (opTaken && opCode == `NCE_OP_NEG
            |=> acc_ff == 4'h0 - $past(acc_ff) && flags_ff[0] == (acc_ff == 4'h0))
        else $error("complement wrong");
    a_branch_abs:
        assert property (opTaken && opCode == `NCE_OP_BRA && flags_ff[0] |=> pc_ff == $past(opAbs))
        else $error("branch target wrong");
    a_call_push:
        assert property (opTaken && (opCode == `NCE_OP_CALA || opCode == `NCE_OP_CALI)
            |=> stackPtr_ff == $past(stackPtr_ff) - {2'h0, $past(flags_ff[0])})
        else $error("call pointer wrong");
    a_bit_status:
        assert property (opTaken && (opCode == `NCE_OP_MBSET || opCode == `NCE_OP_MBCLR)
            |=> flags_ff[0])
        else $error("bit op status low");
endmodule // nce_execute_asserts

bind nce_execute nce_execute_asserts u_chk (.sys_clk(sys_clk), .reset(reset),
    .opValid(opValid), .opCode(opCode), .opAbs(opAbs), .busy_ff(busy_ff), .acc_ff(acc_ff),
    .flags_ff(flags_ff), .pc_ff(pc_ff), .romAddr_ff(romAddr_ff), .addrBuf_ff(addrBuf_ff),
    .stackPtr_ff(stackPtr_ff));

// ===== tb/nce_rom_model.sv
// Program ROM stand-in that answers any word address with a pattern made from its low address byte.
// Assumes the execute unit samples romWord the cycle after it shows romAddr.
module nce_rom_model (
    input wire [14:0] romAddr,
    output wire [15:0] romWord
);
    timeunit 1ns;
    timeprecision 1ns;
    // Combinational read keeps the word valid for the whole cycle after the address
    assign romWord = {romAddr[7:0], ~romAddr[7:0]} ^ 16'hA53C;
endmodule // nce_rom_model

// ===== tb/nibble_cpu_instruction_execute_tb_top.sv
// Self-checking bench: random decoded ops against an integer model of the core.
// Assumes nce_defs.vh on the include path and the ROM stand-in beside it.
`include "nce_defs.vh"
module nibble_cpu_instruction_execute_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic opValid = 1'b0;
    logic [5:0] opCode = 6'h00;
    logic [2:0] opTarget = 3'h0;
    logic [1:0] opSource = 2'h0;
    logic [3:0] opImm = 4'h0;
    logic [1:0] opSel = 2'h0;
    logic [7:0] opDirect = 8'h00;
    logic [13:0] opAbs = 14'h0000;
    wire [15:0] romWord, dataBuf_ff;
    wire [14:0] romAddr_ff, addrBuf_ff;
    wire [13:0] pc_ff;
    wire [3:0] acc_ff, xIdx_ff, yIdx_ff, flags_ff;
    wire [2:0] stackPtr_ff, flagStackPtr_ff;
    wire busy_ff, romPage_ff, wdClear_ff;
    int acc, x, y, c, s, d, irq, ab, db, sptr, fsp, epc, seed = 78, err_total, cmp_count;
    int op, tg, sr, sl;
    int mem [0:255];
    int per [0:63];
    always #5 sys_clk = ~sys_clk;
    nce_execute u_dut (.sys_clk(sys_clk), .reset(reset), .opValid(opValid), .opCode(opCode),
        .opTarget(opTarget), .opSource(opSource), .opImm(opImm), .opSel(opSel),
        .opDirect(opDirect), .opAbs(opAbs), .romWord(romWord), .busy_ff(busy_ff),
        .acc_ff(acc_ff), .xIdx_ff(xIdx_ff), .yIdx_ff(yIdx_ff), .flags_ff(flags_ff), .pc_ff(pc_ff),
        .romPage_ff(romPage_ff), .romAddr_ff(romAddr_ff), .addrBuf_ff(addrBuf_ff),
        .dataBuf_ff(dataBuf_ff), .stackPtr_ff(stackPtr_ff), .flagStackPtr_ff(flagStackPtr_ff),
        .wdClear_ff(wdClear_ff));
    nce_rom_model u_rom (.romAddr(romAddr_ff), .romWord(romWord));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic int rn(input int m);
        return ($random(seed) & 32'h7FFFFFFF) % m;
    endfunction
    task automatic step(input int op, tg, sr, im, sl, dr, ba);
        int a, v, r, ad, sh, ps;
        ad = d ? (dr + x + y) & 255 : dr;
        v = sr == 0 ? im : sr == 1 ? acc : sr == 2 ? y : mem[ad];
        sh = 4 * sl;
        ps = s;
        s = 1;
        epc = -1;
        @(posedge sys_clk);
        opValid <= 1'b1;
        opCode <= op[5:0];
        opTarget <= tg[2:0];
        opSource <= sr[1:0];
        opImm <= im[3:0];
        opSel <= sl[1:0];
        opDirect <= dr[7:0];
        opAbs <= ba[13:0];
        case (op)
            `NCE_OP_ADD, `NCE_OP_SUB:
            begin
                a = tg == 0 ? acc : tg == 1 ? mem[ad] : tg == 4 ? x : y;
                a = tg == 2 ? ab >> sh & 15 : tg == 3 ? db >> sh & 15 : a;
                r = op == `NCE_OP_ADD ? a + v + c : a - v - c;
                c = r >> 4 & 1;
                s = op == `NCE_OP_ADD ? c : 1 - c;
                r = r & 15;
                acc = tg < 2 ? r : acc;
                // Top address nibble is three bits wide
                ab = tg == 2 ? (ab & ~(15 << sh) | r << sh) & 32767 : ab;
                db = tg == 3 ? db & ~(15 << sh) | r << sh : db;
                x = tg == 4 ? r : x;
                y = tg == 5 ? r : y;
            end
            `NCE_OP_ROR: {acc, c} = {28'h0, c[0], acc[3:1], 31'h0, acc[0]};
            `NCE_OP_ALE: s = acc <= v;
            `NCE_OP_ANE: s = acc != v;
            `NCE_OP_MLE: s = mem[ad] <= im;
            `NCE_OP_MNE: s = mem[ad] != im;
            `NCE_OP_YNE: s = y != v;
            `NCE_OP_XNE: s = x != im;
            `NCE_OP_MBSET: mem[ad] |= 1 << sl;
            `NCE_OP_MBCLR: mem[ad] &= ~(1 << sl);
            `NCE_OP_TBIT: s = mem[ad] >> sl & 1;
            `NCE_OP_PSET: per[dr & 63] |= 1 << sl;
            `NCE_OP_PCLR: per[dr & 63] &= ~(1 << sl);
            `NCE_OP_PTST: s = per[dr & 63] >> sl & 1;
            `NCE_OP_CYCLR: c = 0;
            `NCE_OP_CYSET: c = 1;
            `NCE_OP_CYTST: s = c;
            `NCE_OP_LDMEM: mem[ad] = v;
            `NCE_OP_SWAP: {acc, mem[ad]} = {mem[ad], acc};
            `NCE_OP_LDWI: db = ((ab & 255) << 8 | ~ab & 255) ^ 16'hA53C;
            `NCE_OP_PLDI: per[dr & 63] = im;
            `NCE_OP_PFRA: per[dr & 63] = acc;
            `NCE_OP_AFRP: acc = per[dr & 63];
            `NCE_OP_LDA: acc = v;
            `NCE_OP_BRA, `NCE_OP_CALA: epc = ps ? ba : -1;
            `NCE_OP_BRI, `NCE_OP_CALI: epc = ps ? ab & 16383 : -1;
            `NCE_OP_RETN: sptr = (sptr + 1) & 7;
            // Flag stack slots hold the reset flags: status 1, others 0
            `NCE_OP_IRET: {sptr, fsp, c, d, irq} = {(sptr + 1) & 7, (fsp + 1) & 7, 96'h0};
            `NCE_OP_IEN: irq = 1;
            `NCE_OP_IDIS: irq = 0;
            `NCE_OP_XEN: d = 1;
            `NCE_OP_XDIS: d = 0;
            `NCE_OP_NEG: {s, acc} = {31'h0, acc == 0, (16 - acc) & 15};
            default: ;
        endcase
        if (op >= `NCE_OP_IEN && op <= `NCE_OP_XDIS)
            s = ps;
        if (op == `NCE_OP_CALA || op == `NCE_OP_CALI)
            sptr = (sptr - ps) & 7;
        @(posedge sys_clk);
        if (op == `NCE_OP_LDWI)
        begin
            // A load offered while busy must be dropped
            opCode <= `NCE_OP_LDA;
            #1;
            chk("tbl", {busy_ff, romAddr_ff}, {1'b1, ab[14:0]});
            @(posedge sys_clk);
        end
        opValid <= 1'b0;
        #1;
        chk("acc", acc_ff, acc);
        chk("xy", {xIdx_ff, yIdx_ff}, {x[3:0], y[3:0]});
        chk("bufs", addrBuf_ff, ab);
        chk("dbuf", dataBuf_ff, db);
        chk("carry", flags_ff[1], c);
        chk("modes", flags_ff[3:2], {irq[0], d[0]});
        if (op < `NCE_OP_MBSET)
            chk("cmp", flags_ff[0], s);
        else
            chk("status", flags_ff[0], s);
        chk("ptrs", {flagStackPtr_ff, stackPtr_ff}, {fsp[2:0], sptr[2:0]});
        chk("busy", {busy_ff, wdClear_ff}, {1'b0, op == `NCE_OP_WDCLR});
        if (epc >= 0)
            chk("pc", pc_ff, epc);
    endtask
    initial
    begin
        for (int run = 0; run < 2; run++)
        begin
            @(posedge sys_clk);
            reset <= 1'b1;
            repeat (6) @(posedge sys_clk);
            reset <= 1'b0;
            {acc, x, y, c, d, irq, ab, db} = 256'h0;
            {s, sptr, fsp} = {32'h1, 32'h7, 32'h7};
            foreach (per[i]) per[i] = 0;
            #1;
            chk("rst", {flags_ff, flagStackPtr_ff, stackPtr_ff, acc_ff}, 14'h07F0);
            for (int i = 0; i < 256; i++)
                step(`NCE_OP_LDMEM, 0, 0, rn(16), 0, i, 0);
            for (int i = 0; i < 1500; i++)
            begin
                op = rn(38);
                tg = rn(6);
                sl = rn(4);
                sr = rn(4);
                if (op == `NCE_OP_IRET) op = 0;
                if (op < 3) sr = (tg == 0 || tg > 3) ? 0 : sr % (tg == 1 ? 2 : 3);
                if (op == `NCE_OP_ALE || op == `NCE_OP_ANE) sr = (sr & 1) * 3;
                if (op == `NCE_OP_YNE || op == `NCE_OP_LDMEM) sr = sr & 1;
                step(op, tg, sr, rn(16), sl, rn(256), rn(16384));
            end
            step(`NCE_OP_IRET, 0, 0, 0, 0, 0, 0);
        end
        summarize();
    end
endmodule // nibble_cpu_instruction_execute_tb_top
